/* src/udi_pkg.sv */
// Package for the USB device address and interrupt block: register map,
// field positions, reset values, timing constants and carrier structs.
// Assumes a 250 MHz peripheral clock and a 32-bit AXI4-Lite register bus.
package udi_pkg;

	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;

	// Register byte offsets
	localparam logic [AXI_ADDR_W-1:0] OFF_FUNCTION_ADDRESS = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_ENABLE_SET   = 8'h10;
	localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_ENABLE_CLEAR = 8'h14;
	localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_MASK_VIEW    = 8'h18;
	localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_STATUS_VIEW  = 8'h1C;
	localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_FLAG_CLEAR   = 8'h20;

	// Function address register fields
	localparam int FADDR_W          = 7;
	localparam int POS_FUNCTION_EN  = 8;
	localparam logic [FADDR_W-1:0] RST_FUNCTION_ADDRESS = 7'h00;
	localparam logic               RST_FUNCTION_ENABLE  = 1'b0;

	// Interrupt bit positions
	localparam int NUM_EP                  = 6;
	localparam int POS_ENDPOINT0_IRQ       = 0;
	localparam int POS_SUSPEND_IRQ         = 8;
	localparam int POS_BUS_RESUME_IRQ      = 9;
	localparam int POS_EXTERNAL_RESUME_IRQ = 10;
	localparam int POS_FRAME_START_IRQ     = 11;
	localparam int POS_BUS_RESET_DONE_IRQ  = 12;
	localparam int POS_WAKEUP_IRQ          = 13;
	localparam int IRQ_W                   = 14;

	localparam logic [IRQ_W-1:0] MASK_BITS  = 14'h2F3F;
	localparam logic [IRQ_W-1:0] BUS_BITS   = 14'h3F00;
	localparam logic [IRQ_W-1:0] RST_MASK   = 14'h0200;
	localparam logic [IRQ_W-1:0] RST_STATUS = 14'h0000;
	// Sources with no mask bit always reach the interrupt line
	localparam logic [IRQ_W-1:0] UNMASKED   = 14'h1000;

	// Suspend detection timing
	localparam int CLK_HZ          = 250_000_000;
	localparam int SUSPEND_IDLE_MS = 3;
	localparam int SUSPEND_IDLE_CYC = SUSPEND_IDLE_MS * (CLK_HZ / 1000);
	localparam int SUSPEND_CNT_W   = 20;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic                  awvalid;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic                  wvalid;
		logic [AXI_DATA_W-1:0] wdata;
		logic [3:0]            wstrb;
		logic                  bready;
		logic                  arvalid;
		logic [AXI_ADDR_W-1:0] araddr;
		logic                  rready;
	} udi_axil_req_t;

	typedef struct packed {
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [AXI_DATA_W-1:0] rdata;
		logic [1:0]            rresp;
	} udi_axil_rsp_t;

	// Causing flags of one endpoint's control/status register
	typedef struct packed {
		logic setup_received;
		logic rx_bank0_full;
		logic rx_bank1_full;
		logic tx_complete;
		logic stall_handshake_sent;
	} udi_ep_flags_t;

	// One-cycle strobes from the serial engine
	typedef struct packed {
		logic bus_activity;
		logic bus_resume;
		logic frame_start;
		logic bus_reset_done;
	} udi_bus_evt_t;

endpackage : udi_pkg

/* src/udi_sync.sv */
// Two-flop synchroniser, one chain per bit.
// Assumes the inputs are asynchronous levels; the output is a clean level.
`timescale 1ns/1ns
module udi_sync
	import udi_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_ff;

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge ref_clk_i) begin
			if (rst_i) begin
				meta_ff[i] <= 1'b0;
				sync_o[i]  <= 1'b0;
			end else begin
				meta_ff[i] <= async_i[i];
				sync_o[i]  <= meta_ff[i];
			end
		end
	end

endmodule : udi_sync

/* src/udi_top.sv */
// USB device function address and interrupt logic behind AXI4-Lite.
// Assumes endpoint flags and bus strobes come from same-clock logic and the
// remote resume request is an asynchronous pin.
//
// Summary of operation
// [R01] Firmware writes the address only after set-address status stage ends.
// [R02] Function address is zero after power-up and after every reset.
// [R03] Function enable reads back its state; writing zero disables endpoints.
// [R04] Firmware sets function enable after a bus reset from the host.
// [R05] Data packets move to and from the host only while enabled.
// [R06] Enable register: a one sets that endpoint's mask bit, zero no effect.
// [R07] Enable register: a one sets suspend, resume, ext resume, frame, wakeup.
// [R08] Disable register: a one clears the matching mask bit, zero no effect.
// [R09] Mask register reads one per enabled source, enable register layout.
// [R10] Bus resume mask bit is enabled after reset.
// [R11] Endpoint status bit rises on any of its five causing flags.
// [R12] Endpoint status stays set until its control/status flag is cleared.
// [R13] Three ms with no bus activity sets suspend flag and enters suspend.
// [R14] Bus event flags clear only by writing one to the clear register.
// [R15] Bus reset done flag sets when a host bus reset completes.
// [R16] While suspended a rising remote resume request sets external resume.
// [R17] Bus reset done status sits at bit 12, no mask bit there.
// [R18] Interrupt output is high while any enabled status bit is set.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module udi_top
	import udi_pkg::*;
#(
	parameter int SUSPEND_CYC = SUSPEND_IDLE_CYC
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_i,
	input  wire udi_axil_req_t              axil_req_i,
	output udi_axil_rsp_t                   axil_rsp_o,
	input  wire udi_ep_flags_t [NUM_EP-1:0] ep_flags_i,
	input  wire udi_bus_evt_t               bus_evt_i,
	input  wire logic                       remote_resume_i,
	output logic [FADDR_W-1:0]              function_address_o,
	output logic                            function_enable_o,
	output logic                            suspended_o,
	output logic                            irq_o
);

	localparam logic [SUSPEND_CNT_W-1:0] SUSP_LAST =
		SUSPEND_CNT_W'(SUSPEND_CYC - 1);

	// Write channel holding state
	logic                  aw_hold_ff;
	logic                  w_hold_ff;
	logic [AXI_ADDR_W-1:0] waddr_ff;
	logic [AXI_DATA_W-1:0] wdata_ff;
	logic [3:0]            wstrb_ff;

	logic [IRQ_W-1:0]         mask_ff;
	logic [IRQ_W-1:0]         bus_flag_ff;
	logic [NUM_EP-1:0]        ep_stat_ff;
	logic [SUSPEND_CNT_W-1:0] idle_cnt_ff;
	logic                     resume_q_ff;

	logic                  wr_fire;
	logic [AXI_DATA_W-1:0] byte_mask;
	logic [AXI_DATA_W-1:0] wr_bits;
	logic                  wr_hit_faddr;
	logic                  wr_hit_set;
	logic                  wr_hit_clr;
	logic                  wr_hit_icr;
	logic                  wr_mapped;
	logic                  rd_mapped;
	logic [AXI_DATA_W-1:0] rd_value;
	logic [IRQ_W-1:0]      mask_set;
	logic [IRQ_W-1:0]      mask_clr;
	logic [IRQ_W-1:0]      flag_clr;
	logic [IRQ_W-1:0]      nxt_bus_flag;
	logic [IRQ_W-1:0]      bus_set;
	logic [IRQ_W-1:0]      status_now;
	logic [NUM_EP-1:0]     ep_raise;
	logic                  resume_sync;
	logic                  resume_rise;
	logic                  suspend_hit;

	udi_sync #(
		.W (1)
	) u_resume_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.async_i   (remote_resume_i),
		.sync_o    (resume_sync)
	);

	// Word decode on bits above the byte lane
	function automatic logic hit(
		input logic [AXI_ADDR_W-1:0] a,
		input logic [AXI_ADDR_W-1:0] off
	);
		hit = (a[AXI_ADDR_W-1:2] == off[AXI_ADDR_W-1:2]);
	endfunction : hit

	assign wr_fire = aw_hold_ff & w_hold_ff & ~axil_rsp_o.bvalid;

	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign byte_mask[8*b +: 8] = {8{wstrb_ff[b]}};
	end

	assign wr_bits      = wdata_ff & byte_mask;
	assign wr_hit_faddr = hit(waddr_ff, OFF_FUNCTION_ADDRESS);
	assign wr_hit_set   = hit(waddr_ff, OFF_IRQ_ENABLE_SET);
	assign wr_hit_clr   = hit(waddr_ff, OFF_IRQ_ENABLE_CLEAR);
	assign wr_hit_icr   = hit(waddr_ff, OFF_IRQ_FLAG_CLEAR);
	assign wr_mapped    = wr_hit_faddr | wr_hit_set | wr_hit_clr | wr_hit_icr
		| hit(waddr_ff, OFF_IRQ_MASK_VIEW)
		| hit(waddr_ff, OFF_IRQ_STATUS_VIEW);

	assign mask_set = (wr_fire & wr_hit_set) ?
		(wr_bits[IRQ_W-1:0] & MASK_BITS) : '0; // R06 R07
	assign mask_clr = (wr_fire & wr_hit_clr) ?
		(wr_bits[IRQ_W-1:0] & MASK_BITS) : '0; // R08
	assign flag_clr = (wr_fire & wr_hit_icr) ?
		(wr_bits[IRQ_W-1:0] & BUS_BITS) : '0; // R14

	// AXI4-Lite slave: one write and one read under way at a time
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			aw_hold_ff         <= 1'b0;
			w_hold_ff          <= 1'b0;
			waddr_ff           <= '0;
			wdata_ff           <= '0;
			wstrb_ff           <= '0;
			axil_rsp_o.awready <= 1'b1;
			axil_rsp_o.wready  <= 1'b1;
			axil_rsp_o.bvalid  <= 1'b0;
			axil_rsp_o.bresp   <= RESP_OKAY;
			axil_rsp_o.arready <= 1'b1;
			axil_rsp_o.rvalid  <= 1'b0;
			axil_rsp_o.rdata   <= '0;
			axil_rsp_o.rresp   <= RESP_OKAY;
		end else begin
			if (axil_req_i.awvalid && axil_rsp_o.awready) begin
				aw_hold_ff         <= 1'b1;
				waddr_ff           <= axil_req_i.awaddr;
				axil_rsp_o.awready <= 1'b0;
			end
			if (axil_req_i.wvalid && axil_rsp_o.wready) begin
				w_hold_ff         <= 1'b1;
				wdata_ff          <= axil_req_i.wdata;
				wstrb_ff          <= axil_req_i.wstrb;
				axil_rsp_o.wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_hold_ff        <= 1'b0;
				w_hold_ff         <= 1'b0;
				axil_rsp_o.bvalid <= 1'b1;
				axil_rsp_o.bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (axil_rsp_o.bvalid && axil_req_i.bready) begin
				axil_rsp_o.bvalid  <= 1'b0;
				axil_rsp_o.awready <= 1'b1;
				axil_rsp_o.wready  <= 1'b1;
			end
			if (axil_req_i.arvalid && axil_rsp_o.arready) begin
				axil_rsp_o.arready <= 1'b0;
				axil_rsp_o.rvalid  <= 1'b1;
				axil_rsp_o.rdata   <= rd_value;
				axil_rsp_o.rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (axil_rsp_o.rvalid && axil_req_i.rready) begin
				axil_rsp_o.rvalid  <= 1'b0;
				axil_rsp_o.arready <= 1'b1;
			end
		end
	end

	// Read data; write-only registers read as zero
	always_comb begin
		rd_value  = '0;
		rd_mapped = 1'b1;
		if (hit(axil_req_i.araddr, OFF_FUNCTION_ADDRESS)) begin
			rd_value[FADDR_W-1:0]    = function_address_o;
			rd_value[POS_FUNCTION_EN] = function_enable_o; // R03
		end else if (hit(axil_req_i.araddr, OFF_IRQ_MASK_VIEW)) begin
			rd_value[IRQ_W-1:0] = mask_ff; // R09
		end else if (hit(axil_req_i.araddr, OFF_IRQ_STATUS_VIEW)) begin
			rd_value[IRQ_W-1:0] = status_now;
		end else if (hit(axil_req_i.araddr, OFF_IRQ_ENABLE_SET) ||
			hit(axil_req_i.araddr, OFF_IRQ_ENABLE_CLEAR) ||
			hit(axil_req_i.araddr, OFF_IRQ_FLAG_CLEAR)) begin
			rd_value = '0;
		end else begin
			rd_mapped = 1'b0;
		end
	end

	// Function address and enable; bus reset returns address to default
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			function_address_o <= RST_FUNCTION_ADDRESS; // R02
			function_enable_o  <= RST_FUNCTION_ENABLE;
		end else begin
			if (bus_evt_i.bus_reset_done) begin
				function_address_o <= RST_FUNCTION_ADDRESS; // R02
			end else if (wr_fire && wr_hit_faddr && wstrb_ff[0]) begin
				function_address_o <= wdata_ff[FADDR_W-1:0]; // R01
			end
			if (wr_fire && wr_hit_faddr && wstrb_ff[1]) begin
				// Endpoints gate packet traffic on this level
				function_enable_o <= wdata_ff[POS_FUNCTION_EN]; // R03 R04 R05
			end
		end
	end

	// Interrupt mask
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mask_ff <= RST_MASK; // R10
		end else begin
			mask_ff <= (mask_ff | mask_set) & ~mask_clr; // R06 R07 R08
		end
	end

	// Endpoint status follows the sticky causing flags
	for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
		assign ep_raise[e] = |ep_flags_i[e]; // R11
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ep_stat_ff <= '0;
		end else begin
			ep_stat_ff <= ep_raise; // R12
		end
	end

	// Idle timer and suspend state
	// A resume in the last idle cycle must not raise a flag without suspend
	assign suspend_hit = ~suspended_o & ~bus_evt_i.bus_activity &
		~bus_evt_i.bus_resume & (idle_cnt_ff == SUSP_LAST);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			idle_cnt_ff <= '0;
			suspended_o <= 1'b0;
		end else if (bus_evt_i.bus_activity || bus_evt_i.bus_resume) begin
			idle_cnt_ff <= '0;
			suspended_o <= 1'b0;
		end else if (suspend_hit) begin
			suspended_o <= 1'b1; // R13
		end else if (!suspended_o) begin
			idle_cnt_ff <= idle_cnt_ff + 1'b1;
		end
	end

	// Remote resume edge, seen only after synchronising
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			resume_q_ff <= 1'b0;
		end else begin
			resume_q_ff <= resume_sync;
		end
	end

	assign resume_rise = resume_sync & ~resume_q_ff;

	// Bus event set vector
	always_comb begin
		bus_set                          = '0;
		bus_set[POS_SUSPEND_IRQ]         = suspend_hit; // R13
		bus_set[POS_BUS_RESUME_IRQ]      = bus_evt_i.bus_resume;
		bus_set[POS_EXTERNAL_RESUME_IRQ] = resume_rise & suspended_o; // R16
		bus_set[POS_FRAME_START_IRQ]     = bus_evt_i.frame_start;
		bus_set[POS_BUS_RESET_DONE_IRQ]  = bus_evt_i.bus_reset_done; // R15 R17
		bus_set[POS_WAKEUP_IRQ]          = bus_evt_i.bus_resume |
			bus_evt_i.bus_reset_done;
	end

	// A set in the same cycle as a clear wins
	assign nxt_bus_flag = ((bus_flag_ff & ~flag_clr) | bus_set) & BUS_BITS; // R14

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			bus_flag_ff <= RST_STATUS;
		end else begin
			bus_flag_ff <= nxt_bus_flag;
		end
	end

	always_comb begin
		status_now                                = bus_flag_ff;
		status_now[POS_ENDPOINT0_IRQ +: NUM_EP]   = ep_stat_ff;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_now & (mask_ff | UNMASKED)); // R18 R17
		end
	end

endmodule : udi_top

/* sim/udi_host_model.sv */
// Host-side bus event source for the address and interrupt bench.
// Assumes the bench requests one-cycle events just after a clock edge.
`timescale 1ns/1ns
module udi_host_model
	import udi_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       idle_i,
	input  wire logic [3:0] pulse_i,
	output udi_bus_evt_t    bus_evt_o
);
	// Bus traffic stops while idle is asked for, so suspend can be reached
	always_ff @(posedge ref_clk_i) begin
		bus_evt_o <= udi_bus_evt_t'({!idle_i, pulse_i[2:0]});
	end
endmodule : udi_host_model

/* sim/udi_top_monitor.sv */
// Checker for the address and interrupt block, bound to its top.
// Assumes it sees only the top ports and the same suspend count.
`timescale 1ns/1ns
module udi_top_monitor
	import udi_pkg::*;
#(
	parameter int SUSPEND_CYC = SUSPEND_IDLE_CYC
) (
	input wire logic                       ref_clk_i,
	input wire logic                       rst_i,
	input wire udi_axil_req_t              axil_req_i,
	input wire udi_axil_rsp_t              axil_rsp_o,
	input wire udi_ep_flags_t [NUM_EP-1:0] ep_flags_i,
	input wire udi_bus_evt_t               bus_evt_i,
	input wire logic                       remote_resume_i,
	input wire logic [FADDR_W-1:0]         function_address_o,
	input wire logic                       function_enable_o,
	input wire logic                       suspended_o,
	input wire logic                       irq_o
);
	logic [19:0] idle_ff;
	logic        wr_fa;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	assign wr_fa = axil_req_i.awvalid && axil_rsp_o.awready
		&& axil_req_i.wvalid && axil_rsp_o.wready
		&& axil_req_i.awaddr == OFF_FUNCTION_ADDRESS;
	// Cycles since the last bus activity or resume
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || bus_evt_i.bus_activity || bus_evt_i.bus_resume)
			idle_ff <= 20'h0;
		else if (idle_ff != 20'hFFFFF)
			idle_ff <= idle_ff + 20'h1;
	end
	chk_reset_zero: assert property (
		$fell(rst_i) |-> function_address_o == '0 && !function_enable_o
		&& !irq_o) else $error("outputs not cleared by reset");
	chk_fen_write: assert property (
		wr_fa && axil_req_i.wstrb[1] |-> ##2 function_enable_o ==
		$past(axil_req_i.wdata[POS_FUNCTION_EN], 2))
		else $error("function enable not written");
	chk_addr_write: assert property (
		wr_fa && axil_req_i.wstrb[0] |-> ##2 function_address_o ==
		$past(axil_req_i.wdata[6:0], 2))
		else $error("function address not written");
	chk_done_irq: assert property (
		bus_evt_i.bus_reset_done |-> ##2 irq_o && function_address_o == '0)
		else $error("bus reset done not raised");
	chk_susp_rise: assert property (
		$rose(suspended_o) |-> idle_ff >= SUSPEND_CYC - 2
		&& idle_ff <= SUSPEND_CYC + 3) else $error("suspend at wrong time");
	chk_susp_reach: assert property (
		idle_ff == SUSPEND_CYC + 4 |-> suspended_o)
		else $error("suspend not entered");
	chk_susp_leave: assert property (
		suspended_o && bus_evt_i.bus_activity |-> ##[1:2] !suspended_o)
		else $error("suspend not left");
	chk_read_hold: assert property (
		axil_rsp_o.rvalid && !axil_req_i.rready |=> axil_rsp_o.rvalid
		&& $stable(axil_rsp_o.rdata)) else $error("read data dropped");
	chk_bad_addr: assert property (
		axil_req_i.arvalid && axil_rsp_o.arready && axil_req_i.araddr ==
		8'h04 |=> axil_rsp_o.rvalid && axil_rsp_o.rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule : udi_top_monitor
bind udi_top udi_top_monitor #(.SUSPEND_CYC(SUSPEND_CYC)) mon_u (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .axil_req_i(axil_req_i),
	.axil_rsp_o(axil_rsp_o), .ep_flags_i(ep_flags_i),
	.bus_evt_i(bus_evt_i), .remote_resume_i(remote_resume_i),
	.function_address_o(function_address_o),
	.function_enable_o(function_enable_o),
	.suspended_o(suspended_o), .irq_o(irq_o));

/* sim/usb_device_irq_and_address_test.sv */
// Self-checking bench for the address and interrupt block.
// Assumes udi_top with a short suspend count and the host model.
`timescale 1ns/1ns
module usb_device_irq_and_address_test;
	import udi_pkg::*;
	localparam int SC = 20;
	logic clk, rst, idle, rres, fe, susp, irq;
	logic [3:0] pls;
	logic [6:0] fa;
	logic [1:0] rs;
	logic [31:0] rd_d, m, st, a;
	logic [31:0] ev [3] = '{32'h3000, 32'h0800, 32'h2200};
	udi_axil_req_t req;
	udi_axil_rsp_t rsp;
	udi_ep_flags_t [NUM_EP-1:0] ep;
	udi_bus_evt_t evt;
	int errors, samples_checked, cyc;
	udi_top #(.SUSPEND_CYC(SC)) dut_u (.ref_clk_i(clk), .rst_i(rst),
		.axil_req_i(req), .axil_rsp_o(rsp), .ep_flags_i(ep),
		.bus_evt_i(evt), .remote_resume_i(rres),
		.function_address_o(fa), .function_enable_o(fe),
		.suspended_o(susp), .irq_o(irq));
	udi_host_model host_u (.ref_clk_i(clk), .idle_i(idle), .pulse_i(pls),
		.bus_evt_o(evt));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors++;
			summarize();
		end
	end
	function automatic logic [31:0] mset(logic [31:0] o, d, logic s);
		return s ? o | (d & MASK_BITS) : o & ~(d & MASK_BITS);
	endfunction : mset
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : ck
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		req.awaddr <= ad;
		req.wdata <= d;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk);
			ta = ta | rsp.awready;
			tw = tw | rsp.wready;
			req.awvalid <= !ta;
			req.wvalid <= !tw;
		end
		req.bready <= 1'b1;
		do @(posedge clk); while (rsp.bvalid !== 1'b1);
		rs = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] ad);
		req.araddr <= ad;
		req.arvalid <= 1'b1;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		@(posedge clk);
		req.rready <= 1'b1;
		do @(posedge clk); while (rsp.rvalid !== 1'b1);
		rd_d = rsp.rdata;
		rs = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd
	task automatic rc(input logic [7:0] ad, input logic [31:0] e);
		rd(ad);
		ck(rd_d, e);
	endtask : rc
	task automatic pulse(input logic [3:0] v);
		pls <= v;
		@(posedge clk);
		pls <= 4'h0;
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		rst = 1'b1;
		idle = 1'b0;
		rres = 1'b0;
		pls = 4'h0;
		req = '0;
		req.wstrb = 4'hF;
		ep = '0;
		m = 32'h200;
		void'($urandom(32'h77CF));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(OFF_FUNCTION_ADDRESS, 32'h0);
		rc(OFF_IRQ_MASK_VIEW, m);
		rc(OFF_IRQ_STATUS_VIEW, 32'h0);
		rc(OFF_IRQ_ENABLE_SET, 32'h0);
		$display("test reset done");
		pulse(4'h1);
		a = $urandom & 32'h7F;
		wr(OFF_FUNCTION_ADDRESS, a | 32'h100);
		ck(fa, a);
		ck(fe, 32'h1);
		wr(OFF_FUNCTION_ADDRESS, a);
		ck(fe, 32'h0);
		rc(OFF_FUNCTION_ADDRESS, a);
		// Upper lane only: enable moves, address must stay
		req.wstrb <= 4'h2;
		wr(OFF_FUNCTION_ADDRESS, 32'h17F);
		req.wstrb <= 4'hF;
		ck(fa, a);
		ck(fe, 32'h1);
		rc(OFF_FUNCTION_ADDRESS, a | 32'h100);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ck(fa, 32'h0);
		ck(fe, 32'h0);
		rc(OFF_IRQ_STATUS_VIEW, 32'h0);
		$display("test address done");
		for (int i = 0; i < 8; i++) begin
			a = $urandom;
			wr(OFF_IRQ_ENABLE_SET, a);
			m = mset(m, a, 1'b1);
			rc(OFF_IRQ_MASK_VIEW, m);
			a = $urandom;
			wr(OFF_IRQ_ENABLE_CLEAR, a);
			m = mset(m, a, 1'b0);
			rc(OFF_IRQ_MASK_VIEW, m);
		end
		ck(rs, RESP_OKAY);
		$display("test mask done");
		wr(OFF_IRQ_ENABLE_SET, 32'h3F3F);
		m = mset(m, 32'h3F3F, 1'b1);
		for (int i = 0; i < NUM_EP; i++) begin
			ep[i] <= udi_ep_flags_t'(5'h1 << (i % 5));
			repeat (3) @(posedge clk);
			a = 32'h1 << i;
			rc(OFF_IRQ_STATUS_VIEW, a);
			ck(irq, 32'h1);
			wr(OFF_IRQ_ENABLE_CLEAR, a);
			m = mset(m, a, 1'b0);
			wr(OFF_IRQ_FLAG_CLEAR, 32'h3FFF);
			rc(OFF_IRQ_STATUS_VIEW, a);
			ck(irq, 32'h0);
			ep[i] <= '0;
			repeat (3) @(posedge clk);
			rc(OFF_IRQ_STATUS_VIEW, 32'h0);
		end
		$display("test endpoint done");
		st = 32'h0;
		for (int i = 0; i < 3; i++) begin
			pulse(4'h1 << i);
			st = st | ev[i];
			rc(OFF_IRQ_STATUS_VIEW, st);
			ck(irq, 32'h1);
		end
		wr(OFF_IRQ_FLAG_CLEAR, 32'h0);
		rc(OFF_IRQ_STATUS_VIEW, st);
		wr(OFF_IRQ_FLAG_CLEAR, 32'h3F00);
		rc(OFF_IRQ_STATUS_VIEW, 32'h0);
		repeat (2) @(posedge clk);
		ck(irq, 32'h0);
		$display("test bus events done");
		rres <= 1'b1;
		repeat (6) @(posedge clk);
		rres <= 1'b0;
		idle <= 1'b1;
		repeat (SC + 6) @(posedge clk);
		ck(susp, 32'h1);
		rc(OFF_IRQ_STATUS_VIEW, 32'h100);
		rres <= 1'b1;
		repeat (6) @(posedge clk);
		rc(OFF_IRQ_STATUS_VIEW, 32'h500);
		idle <= 1'b0;
		repeat (4) @(posedge clk);
		ck(susp, 32'h0);
		$display("test suspend done");
		rd(8'h04);
		ck(rs, RESP_SLVERR);
		wr(8'h04, 32'hFFFF);
		ck(rs, RESP_SLVERR);
		rc(OFF_IRQ_MASK_VIEW, m);
		$display("test unmapped done");
		summarize();
	end
endmodule : usb_device_irq_and_address_test
